// [core/expander_link_if.sv]
// Signals between the line sampler, the pin drivers and the serial core
interface expander_link_if;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;
    logic ext_reset;
    logic [2:0] addr_level;
    logic [7:0] pin_level;
    logic [7:0] out_value;
    logic [7:0] invert;
    logic [7:0] direction;
    logic [7:0] input_level;

    modport sampler(output scl_rise, scl_fall, start_seen, stop_seen, sda_level, ext_reset, addr_level, pin_level);
    modport ports(input out_value, invert, direction, pin_level, output input_level);
    modport core(input scl_rise, scl_fall, start_seen, stop_seen, sda_level, ext_reset, addr_level, pin_level,
                 input input_level, output out_value, invert, direction);
endinterface : expander_link_if

// [core/expander_map.svh]
// Register pointers, reset values and fixed figures of the port expander
`ifndef EXPANDER_MAP_SVH
`define EXPANDER_MAP_SVH

`define PTR_INPUT 2'h0
`define PTR_OUTPUT 2'h1
`define PTR_INVERT 2'h2
`define PTR_DIRECTION 2'h3

`define RST_POINTER 2'h0
`define RST_OUTPUT 8'h00
`define RST_INVERT 8'hf0
`define RST_DIRECTION 8'hff

// Fixed upper four bits of the 7-bit slave address
`define ADDR_UPPER 4'h5

`define BYTE_BITS 4'h8
`define LAST_SEND_BIT 4'h7
`define COUNT_ZERO 4'h0
`define COUNT_STEP 4'h1

`define CLK_PERIOD_NS 100
`define RESET_PULSE_NS 2
`define RESET_PULSE_CYCLES ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [core/expander_pkg.sv]
// Types shared by the port expander modules
package expander_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_recv,
        st_ack,
        st_send,
        st_mack,
        st_ignore
    } link_state_t;

    typedef enum logic [1:0] {
        ph_addr,
        ph_cmd,
        ph_data
    } phase_t;

    typedef struct packed {
        link_state_t state;
        link_state_t after;
        phase_t phase;
        logic [3:0] count;
        logic [7:0] shift;
        logic [1:0] pointer;
        logic [7:0] out_value;
        logic [7:0] invert;
        logic [7:0] direction;
        logic master_nack;
    } core_state_t;

    typedef struct packed {
        logic [1:0] scl;
        logic [1:0] sda;
        logic [1:0] rst_n;
        logic scl_prev;
        logic sda_prev;
        logic [2:0] addr_meta;
        logic [2:0] addr_sync;
        logic [7:0] pin_meta;
        logic [7:0] pin_sync;
    } sampler_state_t;

endpackage : expander_pkg

// [core/line_sampler.sv]
// Two-stage synchronisers and bus condition detection for all outside inputs
module line_sampler (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic ext_reset_n,
    input wire logic [2:0] addr_select,
    input wire logic [7:0] port_in,
    expander_link_if.sampler link
);
    expander_pkg::sampler_state_t s_reg;
    expander_pkg::sampler_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.scl = {s_reg.scl[0], scl_in};
        s_next.sda = {s_reg.sda[0], sda_in};
        s_next.rst_n = {s_reg.rst_n[0], ext_reset_n};
        s_next.scl_prev = s_reg.scl[1];
        s_next.sda_prev = s_reg.sda[1];
        s_next.addr_meta = addr_select;
        s_next.addr_sync = s_reg.addr_meta;
        s_next.pin_meta = port_in;
        s_next.pin_sync = s_reg.pin_meta;
        if (reset) begin
            // Idle bus; external reset seen as asserted until sampled high
            s_next = '0;
            s_next.scl = 2'h3;
            s_next.sda = 2'h3;
            s_next.scl_prev = 1'h1;
            s_next.sda_prev = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign link.scl_rise = s_reg.scl[1] & ~s_reg.scl_prev;
    assign link.scl_fall = ~s_reg.scl[1] & s_reg.scl_prev;
    assign link.start_seen = s_reg.scl[1] & s_reg.scl_prev & s_reg.sda_prev & ~s_reg.sda[1];
    assign link.stop_seen = s_reg.scl[1] & s_reg.scl_prev & ~s_reg.sda_prev & s_reg.sda[1];
    assign link.sda_level = s_reg.sda[1];
    assign link.ext_reset = ~s_reg.rst_n[1];
    assign link.addr_level = s_reg.addr_sync;
    assign link.pin_level = s_reg.pin_sync;
endmodule : line_sampler

// [core/port_pin_driver.sv]
// Port pin drivers and the inverted input view
module port_pin_driver (
    expander_link_if.ports link,
    output logic [7:0] port_out,
    output logic [7:0] port_drive_n
);
    // Pin 0 can only sink; it never drives high
    assign port_out[0] = 1'h0;
    assign port_drive_n[0] = link.direction[0] | link.out_value[0];

    genvar i;
    generate
        for (i = 1; i < 8; i++) begin : g_push_pull
            assign port_out[i] = link.out_value[i];
            assign port_drive_n[i] = link.direction[i];
        end
    endgenerate

    // Inversion only on pins set as inputs
    assign link.input_level = link.pin_level ^ (link.invert & link.direction);
endmodule : port_pin_driver

// [core/smbus_octal_io_expander.sv]
// SMBus slave with eight port pins and four byte registers behind a pointer
`include "expander_map.svh"

module smbus_octal_io_expander (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_drive_n,
    input wire logic ext_reset_n,
    input wire logic addr_select_bit0,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit2,
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_drive_n
);
    expander_link_if link();

    expander_pkg::core_state_t c_reg;
    expander_pkg::core_state_t c_next;

    logic rst;
    logic [6:0] own_addr;
    logic byte_end;
    logic read_load;

    line_sampler u_sampler (
        .clk(clk),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ext_reset_n(ext_reset_n),
        .addr_select({addr_select_bit2, addr_select_bit1, addr_select_bit0}),
        .port_in(port_in),
        .link(link.sampler)
    );

    port_pin_driver u_pins (
        .link(link.ports),
        .port_out(port_out),
        .port_drive_n(port_drive_n)
    );

    // Power-on and external reset act alike
    assign rst = reset | link.ext_reset;

    assign own_addr = {`ADDR_UPPER, link.addr_level};

    assign byte_end = (c_reg.state == expander_pkg::st_recv) && link.scl_fall && (c_reg.count == `BYTE_BITS);
    assign read_load = (c_reg.state == expander_pkg::st_ack) && link.scl_fall
                       && (c_reg.after == expander_pkg::st_send);

    function automatic logic [7:0] read_select(
        input logic [1:0] ptr,
        input expander_pkg::core_state_t s,
        input logic [7:0] level
    );
        if (ptr == `PTR_INPUT) begin
            read_select = level;
        end else if (ptr == `PTR_OUTPUT) begin
            read_select = s.out_value;
        end else if (ptr == `PTR_INVERT) begin
            read_select = s.invert;
        end else begin
            read_select = s.direction;
        end
    endfunction : read_select

    always_comb begin
        c_next = c_reg;
        case (c_reg.state)
            expander_pkg::st_recv: begin
                if (link.scl_rise) begin
                    c_next.shift = {c_reg.shift[6:0], link.sda_level};
                    c_next.count = c_reg.count + `COUNT_STEP;
                end else if (byte_end) begin
                    c_next.count = `COUNT_ZERO;
                    c_next.state = expander_pkg::st_ack;
                    c_next.after = expander_pkg::st_recv;
                    case (c_reg.phase)
                        expander_pkg::ph_addr: begin
                            if (c_reg.shift[7:1] != own_addr) begin
                                c_next.state = expander_pkg::st_ignore;
                            end else if (c_reg.shift[0]) begin
                                c_next.after = expander_pkg::st_send;
                            end else begin
                                c_next.phase = expander_pkg::ph_cmd;
                            end
                        end
                        expander_pkg::ph_cmd: begin
                            c_next.pointer = c_reg.shift[1:0];
                            c_next.phase = expander_pkg::ph_data;
                        end
                        default: begin
                            // Write takes effect at its acknowledge
                            if (c_reg.pointer == `PTR_OUTPUT) begin
                                c_next.out_value = c_reg.shift;
                            end else if (c_reg.pointer == `PTR_INVERT) begin
                                c_next.invert = c_reg.shift;
                            end else if (c_reg.pointer == `PTR_DIRECTION) begin
                                c_next.direction = c_reg.shift;
                            end else begin
                                c_next.shift = c_reg.shift;
                            end
                        end
                    endcase
                end
            end
            expander_pkg::st_ack: begin
                if (link.scl_fall) begin
                    c_next.state = c_reg.after;
                    if (c_reg.after == expander_pkg::st_send) begin
                        // Register sampled at the end of the acknowledge
                        c_next.shift = read_select(c_reg.pointer, c_reg, link.input_level);
                    end
                end
            end
            expander_pkg::st_send: begin
                if (link.scl_fall) begin
                    if (c_reg.count == `LAST_SEND_BIT) begin
                        c_next.state = expander_pkg::st_mack;
                        c_next.count = `COUNT_ZERO;
                    end else begin
                        c_next.shift = {c_reg.shift[6:0], 1'h0};
                        c_next.count = c_reg.count + `COUNT_STEP;
                    end
                end
            end
            expander_pkg::st_mack: begin
                if (link.scl_rise) begin
                    c_next.master_nack = link.sda_level;
                end else if (link.scl_fall) begin
                    if (c_reg.master_nack) begin
                        c_next.state = expander_pkg::st_ignore;
                    end else begin
                        c_next.state = expander_pkg::st_send;
                        c_next.shift = read_select(c_reg.pointer, c_reg, link.input_level);
                    end
                end
            end
            default: begin
                c_next.state = c_reg.state;
            end
        endcase

        // Repeated start restarts address reception
        if (link.start_seen) begin
            c_next.state = expander_pkg::st_recv;
            c_next.phase = expander_pkg::ph_addr;
            c_next.count = `COUNT_ZERO;
        end
        // Stop drops any read in progress; acknowledged writes stay
        if (link.stop_seen) begin
            c_next.state = expander_pkg::st_idle;
        end

        if (rst) begin
            c_next = '0;
            c_next.state = expander_pkg::st_idle;
            c_next.after = expander_pkg::st_idle;
            c_next.phase = expander_pkg::ph_addr;
            c_next.pointer = `RST_POINTER;
            c_next.out_value = `RST_OUTPUT;
            c_next.invert = `RST_INVERT;
            c_next.direction = `RST_DIRECTION;
        end
    end

    always_ff @(posedge clk) begin
        c_reg <= c_next;
    end

    assign link.out_value = c_reg.out_value;
    assign link.invert = c_reg.invert;
    assign link.direction = c_reg.direction;

    // Data line is open drain: only ever pulled low
    assign sda_out = 1'h0;
    assign sda_drive_n = ~((c_reg.state == expander_pkg::st_ack)
                         || ((c_reg.state == expander_pkg::st_send) && !c_reg.shift[7]));

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    a_cmd_pointer_store: assert property (
        byte_end && (c_reg.phase == expander_pkg::ph_cmd) |=> c_reg.pointer == $past(c_reg.shift[1:0]))
        else $error("command byte not stored as pointer");

    a_ro_write_ignored: assert property (
        byte_end && (c_reg.phase == expander_pkg::ph_data) && (c_reg.pointer == `PTR_INPUT)
        |=> $stable(c_reg.out_value) && $stable(c_reg.invert) && $stable(c_reg.direction))
        else $error("write to input register changed state");

    a_dir_write_lands: assert property (
        byte_end && (c_reg.phase == expander_pkg::ph_data) && (c_reg.pointer == `PTR_DIRECTION)
        |=> c_reg.direction == $past(c_reg.shift) && c_reg.state == expander_pkg::st_ack)
        else $error("direction write lost");

    a_out_write_lands: assert property (
        byte_end && (c_reg.phase == expander_pkg::ph_data) && (c_reg.pointer == `PTR_OUTPUT)
        |=> c_reg.out_value == $past(c_reg.shift) ##1 port_out[7:1] == c_reg.out_value[7:1])
        else $error("output write not on pins");

    a_ack_drives_low: assert property (
        c_reg.state == expander_pkg::st_ack |-> !sda_drive_n)
        else $error("acknowledge not driven");

    a_addr_mismatch: assert property (
        byte_end && (c_reg.phase == expander_pkg::ph_addr) && (c_reg.shift[7:1] != own_addr)
        && !link.start_seen && !link.stop_seen |=> c_reg.state == expander_pkg::st_ignore && sda_drive_n)
        else $error("foreign address answered");

    a_read_pointer: assert property (
        read_load && !link.start_seen && !link.stop_seen
        |=> c_reg.shift == read_select($past(c_reg.pointer), $past(c_reg), $past(link.input_level)))
        else $error("read data not from pointer register");

    a_input_invert: assert property (
        read_load && (c_reg.pointer == `PTR_INPUT) && !link.start_seen && !link.stop_seen
        |=> c_reg.shift == $past(link.pin_level ^ (c_reg.invert & c_reg.direction)))
        else $error("input inversion wrong");

    a_send_bit: assert property (
        c_reg.state == expander_pkg::st_send |-> sda_drive_n == c_reg.shift[7])
        else $error("sent bit differs from shift register");

    a_stop_ends: assert property (
        link.stop_seen |=> c_reg.state == expander_pkg::st_idle && sda_drive_n)
        else $error("stop did not end transfer");

    a_pin0_open_drain: assert property (
        !port_drive_n[0] |-> !port_out[0] && !c_reg.direction[0] && !c_reg.out_value[0])
        else $error("pin 0 driven high or as input");

    a_dir_release: assert property (
        (port_drive_n[7:1] | ~c_reg.direction[7:1]) == 7'h7f && (!c_reg.direction[0] || port_drive_n[0]))
        else $error("input pin driven");

    a_reset_defaults: assert property (
        @(posedge clk) disable iff (reset) link.ext_reset
        |=> c_reg.direction == `RST_DIRECTION && c_reg.out_value == `RST_OUTPUT
        && c_reg.invert == `RST_INVERT && c_reg.pointer == `RST_POINTER && port_drive_n == 8'hff)
        else $error("external reset left non-default state");

    c_write_byte: cover property (
        byte_end && (c_reg.phase == expander_pkg::ph_data) && (c_reg.pointer == `PTR_OUTPUT));

    c_read_byte: cover property (
        (c_reg.state == expander_pkg::st_mack) && link.scl_fall && c_reg.master_nack);

    c_read_continue: cover property (
        (c_reg.state == expander_pkg::st_mack) && link.scl_fall && !c_reg.master_nack);

    c_stop_in_read: cover property (
        (c_reg.state == expander_pkg::st_send) && link.stop_seen);
endmodule : smbus_octal_io_expander

// [tb/smbus_host_model.sv]
// Behavioural SMBus host that clocks bytes into and out of the expander
module smbus_host_model (
    input wire logic clk,
    input wire logic sda_drive_n,
    input wire logic sda_out,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic scl_reg = 1'b1;
    logic sda_reg = 1'b1;

    // Pulled-up wire, low whenever either party pulls it
    assign scl = scl_reg;
    assign sda = sda_reg & (sda_drive_n | sda_out);

    // Quarter of the 800 ns link period
    task quarter;
        repeat (2) @(posedge clk);
    endtask : quarter

    // Also serves as repeated start, since data is raised first
    task start_cond;
        sda_reg <= 1'b1;
        quarter;
        scl_reg <= 1'b1;
        quarter;
        sda_reg <= 1'b0;
        quarter;
        scl_reg <= 1'b0;
        quarter;
    endtask : start_cond

    // Clock is left high afterwards: it stands still between frames
    task stop_cond;
        sda_reg <= 1'b0;
        quarter;
        scl_reg <= 1'b1;
        quarter;
        sda_reg <= 1'b1;
        quarter;
    endtask : stop_cond

    // Data only changes while the clock is low
    task clock_bit(input logic b, output logic r);
        sda_reg <= b;
        quarter;
        scl_reg <= 1'b1;
        quarter;
        r = sda;
        quarter;
        scl_reg <= 1'b0;
        quarter;
    endtask : clock_bit

    task send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], r);
        end
        clock_bit(1'b1, r);
        ack = !r;
    endtask : send_byte

    task recv_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(!more, r);
    endtask : recv_byte

    // Cuts a transfer short; caller must pick n so the slave is not holding data low
    task bits_then_stop(input int n);
        logic r;
        for (int i = 0; i < n; i++) begin
            clock_bit(1'b1, r);
        end
        stop_cond;
    endtask : bits_then_stop
endmodule : smbus_host_model

// [tb/smbus_octal_io_expander_tb_top.sv]
// Self-checking bench for the SMBus port expander
`include "expander_map.svh"

`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end

module smbus_octal_io_expander_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ext_reset_n = 1'b1;
    logic [2:0] addr_pins = 3'h5;
    logic [7:0] pin_ext = 8'h00;
    logic scl;
    logic sda;
    logic sda_out;
    logic sda_drive_n;
    logic [7:0] port_out;
    logic [7:0] port_drive_n;
    logic [7:0] pins;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    assign pins = (~port_drive_n & port_out) | (port_drive_n & pin_ext);

    smbus_octal_io_expander smbus_octal_io_expander_i (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_drive_n(sda_drive_n), .ext_reset_n(ext_reset_n), .addr_select_bit0(addr_pins[0]),
        .addr_select_bit1(addr_pins[1]), .addr_select_bit2(addr_pins[2]), .port_in(pins),
        .port_out(port_out), .port_drive_n(port_drive_n)
    );

    smbus_host_model smbus_host_model_i (
        .clk(clk), .sda_drive_n(sda_drive_n), .sda_out(sda_out), .scl(scl), .sda(sda)
    );

    task results;
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task write_reg(input logic [7:0] cmd, input logic [7:0] d);
        logic a1, a2, a3;
        smbus_host_model_i.start_cond;
        smbus_host_model_i.send_byte({`ADDR_UPPER, addr_pins, 1'b0}, a1);
        smbus_host_model_i.send_byte(cmd, a2);
        smbus_host_model_i.send_byte(d, a3);
        smbus_host_model_i.stop_cond;
        `CHECK("write acks", 3'b111, {a1, a2, a3})
    endtask : write_reg

    task check_reg(input logic [7:0] cmd, input logic [7:0] exp, input string name);
        logic a1, a2, a3;
        logic [7:0] d;
        smbus_host_model_i.start_cond;
        smbus_host_model_i.send_byte({`ADDR_UPPER, addr_pins, 1'b0}, a1);
        smbus_host_model_i.send_byte(cmd, a2);
        smbus_host_model_i.start_cond;
        smbus_host_model_i.send_byte({`ADDR_UPPER, addr_pins, 1'b1}, a3);
        smbus_host_model_i.recv_byte(1'b0, d);
        smbus_host_model_i.stop_cond;
        `CHECK("read acks", 3'b111, {a1, a2, a3})
        `CHECK(name, exp, d)
    endtask : check_reg

    task receive(input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        smbus_host_model_i.start_cond;
        smbus_host_model_i.send_byte({`ADDR_UPPER, addr_pins, 1'b1}, a);
        smbus_host_model_i.recv_byte(1'b0, d);
        smbus_host_model_i.stop_cond;
        `CHECK("receive ack", 1'b1, a)
        `CHECK("receive data", exp, d)
    endtask : receive

    task t_defaults;
        pin_ext <= 8'h3c;
        repeat (4) @(posedge clk);
        `CHECK("drive_n", 8'hff, port_drive_n)
        `CHECK("port_out", `RST_OUTPUT, port_out)
        `CHECK("sda_out", 1'b0, sda_out)
        receive(8'h3c ^ `RST_INVERT);
        check_reg(8'h01, `RST_OUTPUT, "output reg");
        check_reg(8'h02, `RST_INVERT, "invert reg");
        check_reg(8'h03, `RST_DIRECTION, "direction reg");
    endtask : t_defaults

    task t_outputs;
        pin_ext <= 8'h00;
        write_reg(8'h03, 8'h00);
        write_reg(8'h01, 8'ha5);
        `CHECK("drive_n", 8'h01, port_drive_n)
        `CHECK("port_out", 8'ha4, port_out)
        check_reg(8'h01, 8'ha5, "output reg");
        check_reg(8'h00, 8'ha4, "input reg");
        write_reg(8'h01, 8'h5a);
        `CHECK("drive_n", 8'h00, port_drive_n)
        `CHECK("port_out", 8'h5a, port_out)
    endtask : t_outputs

    task t_invert;
        pin_ext <= 8'h09;
        write_reg(8'h03, 8'h0f);
        write_reg(8'h02, 8'h33);
        `CHECK("drive_n", 8'h0f, port_drive_n)
        check_reg(8'h00, 8'h5a, "input reg");
    endtask : t_invert

    // Upper command bits are ignored, so 0xfd points at the output register
    task t_pointer;
        logic a;
        logic [7:0] d1, d2;
        write_reg(8'h00, 8'hff);
        check_reg(8'h03, 8'h0f, "direction reg");
        check_reg(8'h02, 8'h33, "invert reg");
        write_reg(8'hfd, 8'h3c);
        `CHECK("port_out", 8'h30, port_out & 8'hf0)
        receive(8'h3c);
        // Host acknowledges the first byte, so the same register is sent again
        smbus_host_model_i.start_cond;
        smbus_host_model_i.send_byte({`ADDR_UPPER, addr_pins, 1'b1}, a);
        smbus_host_model_i.recv_byte(1'b1, d1);
        smbus_host_model_i.recv_byte(1'b0, d2);
        smbus_host_model_i.stop_cond;
        `CHECK("burst ack", 1'b1, a)
        `CHECK("burst data", 16'h3c3c, {d1, d2})
    endtask : t_pointer

    task t_address;
        logic a;
        smbus_host_model_i.start_cond;
        smbus_host_model_i.send_byte({`ADDR_UPPER, addr_pins ^ 3'h1, 1'b0}, a);
        smbus_host_model_i.stop_cond;
        `CHECK("foreign ack", 1'b0, a)
        addr_pins <= 3'h2;
        repeat (4) @(posedge clk);
        write_reg(8'h01, 8'hc3);
        `CHECK("port_out", 8'hc0, port_out & 8'hf0)
    endtask : t_address

    // Read abort leaves the slave releasing: bit 0 of 0x81 is one
    task t_abort;
        logic a1, a2, a3;
        smbus_host_model_i.start_cond;
        smbus_host_model_i.send_byte({`ADDR_UPPER, addr_pins, 1'b0}, a1);
        smbus_host_model_i.send_byte(8'h01, a2);
        smbus_host_model_i.send_byte(8'h81, a3);
        smbus_host_model_i.bits_then_stop(4);
        `CHECK("port_out", 8'h80, port_out & 8'hf0)
        smbus_host_model_i.start_cond;
        smbus_host_model_i.send_byte({`ADDR_UPPER, addr_pins, 1'b1}, a1);
        smbus_host_model_i.bits_then_stop(7);
        receive(8'h81);
    endtask : t_abort

    task t_resets;
        write_reg(8'h03, 8'h00);
        ext_reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        ext_reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHECK("drive_n", 8'hff, port_drive_n)
        `CHECK("port_out", 8'h00, port_out)
        check_reg(8'h03, `RST_DIRECTION, "direction reg");
        write_reg(8'h03, 8'h00);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        `CHECK("drive_n", 8'hff, port_drive_n)
        receive(8'h09 ^ `RST_INVERT);
    endtask : t_resets

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            results;
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        t_defaults;
        t_outputs;
        t_invert;
        t_pointer;
        t_address;
        t_abort;
        t_resets;
        results;
    end
endmodule : smbus_octal_io_expander_tb_top
